//--- design/parc_defs.svh
// Constants of the packet acknowledgement and retry controller.
// Assumes one 50 MHz clock and a host that issues byte-wide parameter commands.
// Behaviour
// - Retry limit is 8 bits, 0 to 255, and resets to zero (disabled).
// - A non-zero retry limit enables acknowledgement wait and retransmission for all packets.
// - After sending, wait for an acknowledgement before treating the packet as delivered.
// - No acknowledgement within the slot window: resend the same held packet.
// - Repeat until acknowledged or transmissions of that packet equal the retry limit.
// - Before resending, wait a random 0 to span-1 slots of 38 ms each.
// - Slot span is 8 bits, resets to zero, used only while retries are on.
`ifndef PARC_DEFS_SVH
`define PARC_DEFS_SVH

// Parameter command codes
`define PARC_CMD_RETRY_LIMIT 8'h18
`define PARC_CMD_SLOT_SPAN   8'h19

// Reset values
`define PARC_RETRY_LIMIT_RST 8'h00
`define PARC_SLOT_SPAN_RST   8'h00

// Timing
`define PARC_SLOT_MS         38
`define PARC_CLK_KHZ         50000
`define PARC_SLOT_CYCLES     (`PARC_SLOT_MS * `PARC_CLK_KHZ)

// Random source seed, any non-zero value
`define PARC_LFSR_SEED       8'hA5

`endif

//--- design/parc_pkg.sv
// Types shared by the retry controller, its port checker and its bench.
// Assumes parc_defs.svh is included by the files that need constants.
package parc_pkg;

  // Parameter command from the host side
  typedef struct packed {
    logic       write;
    logic [7:0] code;
    logic [7:0] wdata;
  } parc_cmd_t;

  // Answer to a parameter command
  typedef struct packed {
    logic       err;
    logic [7:0] data;
  } parc_rsp_t;

  // Controller states, one-hot
  typedef enum logic [5:0] {
    PARC_IDLE    = 6'h01,
    PARC_SEND    = 6'h02,
    PARC_TXWAIT  = 6'h04,
    PARC_ACKWAIT = 6'h08,
    PARC_BACKOFF = 6'h10,
    PARC_DONE    = 6'h20
  } parc_state_t;

endpackage

//--- design/parc_lfsr.sv
// Free-running 8-bit pseudo-random source for the backoff slot choice.
// Assumes nothing of its surroundings beyond clock and reset.
`timescale 1ns/10ps
`include "parc_defs.svh"
module parc_lfsr (
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  output logic      [7:0] rnd
);
  logic [7:0] lfsr_q;
  logic [7:0] lfsr_d;

  // Galois taps 8,6,5,4; the all-zero state is never reached from the seed
  assign lfsr_d = lfsr_q[0] ? ({1'b0, lfsr_q[7:1]} ^ 8'hB8) : {1'b0, lfsr_q[7:1]};
  assign rnd    = lfsr_q;

  // Advances every cycle so the draw depends on traffic timing
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) lfsr_q <= `PARC_LFSR_SEED;
    else       lfsr_q <= lfsr_d;
  end
endmodule

//--- design/parc_top.sv
// Acknowledgement and retransmission controller for outgoing radio packets.
// Assumes the radio engine on the same clock sends the held packet on rf_send,
// reports rf_tx_done when it is on air and rf_ack when the peer acknowledges.
`timescale 1ns/10ps
`include "parc_defs.svh"
module parc_top #(
  parameter int unsigned SLOT_CYCLES = `PARC_SLOT_CYCLES
) (
  input  wire logic                 sys_clk,
  input  wire logic                 rstn,
  input  wire logic                 cmd_valid,
  input  wire parc_pkg::parc_cmd_t  cmd,
  output logic                      rsp_valid,
  output parc_pkg::parc_rsp_t       rsp,
  input  wire logic                 pkt_valid,
  input  wire logic          [15:0] pkt_ref,
  output logic                      pkt_ready,
  output logic                      rf_send,
  output logic               [15:0] rf_ref,
  input  wire logic                 rf_tx_done,
  input  wire logic                 rf_ack,
  output logic                      pkt_done,
  output logic                      pkt_acked,
  output logic                      retry_active
);
  parc_pkg::parc_state_t state_q;
  parc_pkg::parc_state_t state_d;

  logic  [7:0] retry_limit_q;
  logic  [7:0] backoff_slot_span_q;
  logic  [7:0] tx_cnt_q;
  logic  [7:0] tx_cnt_d;
  logic  [7:0] slots_left_q;
  logic  [7:0] slots_left_d;
  logic [20:0] slot_cyc_q;
  logic [15:0] ref_q;
  logic        rsp_valid_q;
  logic        rsp_err_q;
  logic  [7:0] rsp_data_q;
  logic        pkt_ready_q;
  logic        rf_send_q;
  logic        pkt_done_q;
  logic        pkt_acked_q;
  logic        acked_d;
  logic        retry_active_q;
  logic  [7:0] rnd;

  // Command decode
  wire         hit_limit = (cmd.code == `PARC_CMD_RETRY_LIMIT);
  wire         hit_span  = (cmd.code == `PARC_CMD_SLOT_SPAN);
  wire         wr_limit  = cmd_valid && cmd.write && hit_limit;
  wire         wr_span   = cmd_valid && cmd.write && hit_span;
  wire   [7:0] rd_data   = hit_limit ? retry_limit_q :
                           hit_span  ? backoff_slot_span_q : 8'h00;

  // Handshakes and status terms
  wire         take_pkt    = pkt_valid && pkt_ready_q;
  wire         retries_on  = (retry_limit_q != 8'h00);
  wire         slot_timing = (state_q == parc_pkg::PARC_ACKWAIT) ||
                             (state_q == parc_pkg::PARC_BACKOFF);
  wire         slot_tick   = slot_timing && (slot_cyc_q == 21'(SLOT_CYCLES - 1));
  wire         last_slot   = slot_tick && (slots_left_q == 8'h01);
  // Greater-or-equal, so a limit lowered in mid-packet still ends the repeats
  wire         limit_hit   = (tx_cnt_q >= retry_limit_q);
  // A zero span still gives the peer one slot to answer
  wire   [7:0] ack_window  = (backoff_slot_span_q == 8'h00) ? 8'h01 : backoff_slot_span_q;
  // Scaled draw: (rnd * span) >> 8 lands in 0 .. span-1 without a divider
  wire  [15:0] rnd_prod    = rnd * backoff_slot_span_q;
  wire   [7:0] backoff_pick = rnd_prod[15:8];

  // Runs freely; the draw is whatever it holds when the ack window expires
  parc_lfsr u_lfsr (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .rnd     (rnd)
  );

  // Sequencing of one packet from acceptance to outcome
  always_comb begin
    state_d      = state_q;
    tx_cnt_d     = tx_cnt_q;
    slots_left_d = slots_left_q;
    acked_d      = pkt_acked_q;
    case (state_q)
      parc_pkg::PARC_IDLE: begin
        if (take_pkt) begin
          tx_cnt_d = 8'h00;
          state_d  = parc_pkg::PARC_SEND;
        end
      end
      parc_pkg::PARC_SEND: begin
        tx_cnt_d = tx_cnt_q + 8'h01;
        state_d  = parc_pkg::PARC_TXWAIT;
      end
      parc_pkg::PARC_TXWAIT: begin
        if (rf_tx_done) begin
          if (!retries_on) begin
            // Disabled: one shot, no acknowledgement expected
            acked_d = 1'b0;
            state_d = parc_pkg::PARC_DONE;
          end else begin
            slots_left_d = ack_window;
            state_d      = parc_pkg::PARC_ACKWAIT;
          end
        end
      end
      parc_pkg::PARC_ACKWAIT: begin
        if (rf_ack) begin
          // Acknowledgement beats a timeout landing in the same cycle
          acked_d  = 1'b1;
          tx_cnt_d = 8'h00;
          state_d  = parc_pkg::PARC_DONE;
        end else if (last_slot) begin
          if (limit_hit) begin
            acked_d = 1'b0;
            state_d = parc_pkg::PARC_DONE;
          end else if (backoff_pick == 8'h00) begin
            state_d = parc_pkg::PARC_SEND;
          end else begin
            slots_left_d = backoff_pick;
            state_d      = parc_pkg::PARC_BACKOFF;
          end
        end else if (slot_tick) begin
          slots_left_d = slots_left_q - 8'h01;
        end
      end
      parc_pkg::PARC_BACKOFF: begin
        if (last_slot) begin
          state_d = parc_pkg::PARC_SEND;
        end else if (slot_tick) begin
          slots_left_d = slots_left_q - 8'h01;
        end
      end
      parc_pkg::PARC_DONE: begin
        state_d = parc_pkg::PARC_IDLE;
      end
      default: begin
        state_d = parc_pkg::PARC_IDLE;
      end
    endcase
  end

  // State and per-packet counters
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_q      <= parc_pkg::PARC_IDLE;
      tx_cnt_q     <= 8'h00;
      slots_left_q <= 8'h00;
      pkt_acked_q  <= 1'b0;
    end else begin
      state_q      <= state_d;
      tx_cnt_q     <= tx_cnt_d;
      slots_left_q <= slots_left_d;
      pkt_acked_q  <= acked_d;
    end
  end

  // Slot timer restarts on every state change so each wait is whole slots
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn)                                  slot_cyc_q <= 21'h000000;
    else if (!slot_timing || state_d != state_q || slot_tick) slot_cyc_q <= 21'h000000;
    else                                        slot_cyc_q <= slot_cyc_q + 21'h000001;
  end

  // Held copy of the packet reference; resends reuse it untouched
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn)         ref_q <= 16'h0000;
    else if (take_pkt) ref_q <= pkt_ref;
  end

  // Parameters; a new value applies from the next decision point
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      retry_limit_q       <= `PARC_RETRY_LIMIT_RST;
      backoff_slot_span_q <= `PARC_SLOT_SPAN_RST;
    end else begin
      if (wr_limit) retry_limit_q       <= cmd.wdata;
      if (wr_span)  backoff_slot_span_q <= cmd.wdata;
    end
  end

  // Command answer, one cycle after the request; unknown codes flag an error
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rsp_valid_q <= 1'b0;
      rsp_err_q   <= 1'b0;
      rsp_data_q  <= 8'h00;
    end else begin
      rsp_valid_q <= cmd_valid;
      rsp_err_q   <= cmd_valid && !hit_limit && !hit_span;
      rsp_data_q  <= cmd_valid ? rd_data : 8'h00;
    end
  end

  // Registered strobes toward the radio and the packet source
  // Ready drops at the take edge so a pkt_valid held high is taken only once
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pkt_ready_q    <= 1'b1;
      rf_send_q      <= 1'b0;
      pkt_done_q     <= 1'b0;
      retry_active_q <= 1'b0;
    end else begin
      pkt_ready_q    <= (state_d == parc_pkg::PARC_IDLE) && !take_pkt;
      rf_send_q      <= (state_d == parc_pkg::PARC_SEND);
      pkt_done_q     <= (state_d == parc_pkg::PARC_DONE);
      retry_active_q <= retries_on;
    end
  end

  // Outputs straight from flip-flops
  assign rsp_valid    = rsp_valid_q;
  assign rsp.err      = rsp_err_q;
  assign rsp.data     = rsp_data_q;
  assign pkt_ready    = pkt_ready_q;
  assign rf_send      = rf_send_q;
  assign rf_ref       = ref_q;
  assign pkt_done     = pkt_done_q;
  assign pkt_acked    = pkt_acked_q;
  assign retry_active = retry_active_q;
endmodule

//--- bench/parc_chk.sv
// Port checker for the retry controller, bound onto parc_top.
// Assumes one clock and a slot of at least eight cycles.
`timescale 1ns/10ps
module parc_chk #(
  parameter int unsigned SLOT_CYCLES = 8
) (
  input wire logic                sys_clk,
  input wire logic                rstn,
  input wire logic                cmd_valid,
  input wire parc_pkg::parc_cmd_t cmd,
  input wire logic                rsp_valid,
  input wire parc_pkg::parc_rsp_t rsp,
  input wire logic                pkt_valid,
  input wire logic         [15:0] pkt_ref,
  input wire logic                pkt_ready,
  input wire logic                rf_send,
  input wire logic         [15:0] rf_ref,
  input wire logic                rf_tx_done,
  input wire logic                rf_ack,
  input wire logic                pkt_done,
  input wire logic                pkt_acked,
  input wire logic                retry_active
);
  logic  [7:0] lim_q;
  logic  [8:0] cnt_q;
  logic [31:0] since_q;
  wire        take = pkt_valid && pkt_ready;
  // Shadow limit, send count of the current packet and cycles since the last tx_done;
  // the count clears on take and after the outcome, a limit change mid-packet is not modelled
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      lim_q   <= 8'h00;
      cnt_q   <= 9'h000;
      since_q <= 32'h00000000;
    end else begin
      if (cmd_valid && cmd.write && cmd.code == 8'h18) lim_q <= cmd.wdata;
      cnt_q   <= (take || pkt_done) ? 9'h000 : cnt_q + {8'h00, rf_send};
      since_q <= rf_tx_done ? 32'h00000000 : since_q + 32'h00000001;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  sequence s_lim_wr;
    cmd_valid && cmd.write && cmd.code == 8'h18 ##1 !(cmd_valid && cmd.write);
  endsequence
  AST_RSP_NEXT: assert property (cmd_valid |=> rsp_valid)
    else $error("command not answered");
  AST_BAD_CODE: assert property (cmd_valid && cmd.code != 8'h18 && cmd.code != 8'h19
    |=> rsp.err && rsp.data == 8'h00) else $error("unknown code accepted");
  AST_ENABLE: assert property (s_lim_wr |=> retry_active == ($past(cmd.wdata, 2) != 8'h00))
    else $error("retry enable wrong");
  AST_TAKE_SEND: assert property (take |=> rf_send && !pkt_ready)
    else $error("no send after take");
  AST_SAME_REF: assert property (take |=> rf_ref == $past(pkt_ref))
    else $error("wrong packet reference");
  AST_ACK_CAUSE: assert property (pkt_done && pkt_acked |-> $past(rf_ack))
    else $error("ack reported without ack");
  AST_OFF_NO_ACK: assert property (pkt_done && !retry_active |-> !pkt_acked)
    else $error("ack while retries off");
  AST_SEND_LIMIT: assert property (cnt_q <= ((lim_q == 8'h00) ? 9'h001 : {1'b0, lim_q}))
    else $error("too many transmissions");
  AST_READY_BACK: assert property (pkt_done |=> pkt_ready)
    else $error("not ready after done");
  AST_GIVE_UP: assert property (pkt_done && !pkt_acked && lim_q != 8'h00
    |-> cnt_q == {1'b0, lim_q}) else $error("gave up at wrong count");
  // A resend lands whole slots after tx_done: ack window plus backoff slots
  AST_SLOT_GRID: assert property (rf_send && cnt_q != 9'h000
    |-> since_q >= SLOT_CYCLES && since_q % SLOT_CYCLES == 0)
    else $error("resend off the slot grid");
  // Eight cycles stands for one slot; holds only while SLOT_CYCLES is at least eight
  AST_WAIT_SLOT: assert property (rf_tx_done && retry_active |=> !rf_send [*8])
    else $error("resend inside ack window");
endmodule

//--- bench/parc_radio.sv
// Behavioural peer radio: a done pulse per send, an ack on one chosen send.
// Assumes the controller clock; ack_on of zero means never acknowledge.
`timescale 1ns/10ps
module parc_radio (
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  input  wire logic       rf_send,
  input  wire logic       clr,
  input  wire logic [7:0] ack_on,
  output logic            rf_tx_done,
  output logic            rf_ack
);
  logic [7:0] sent_q;
  logic [2:0] age_q;
  logic       busy_q;
  // Three cycles of airtime, ack two cycles after the done pulse
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      {sent_q, age_q, busy_q, rf_tx_done, rf_ack} <= '0;
    end else begin
      rf_tx_done <= busy_q && age_q == 3'h2;
      rf_ack     <= busy_q && age_q == 3'h4 && sent_q == ack_on;
      age_q      <= rf_send ? 3'h0 : age_q + 3'h1;
      busy_q     <= rf_send || (busy_q && age_q != 3'h4);
      sent_q     <= clr ? 8'h00 : sent_q + {7'h00, rf_send};
    end
  end
endmodule

//--- bench/tb.sv
// Self-checking bench for the retry controller with a peer radio model.
// Assumes a 50 MHz clock and a slot shortened to eight cycles.
`timescale 1ns/10ps
module tb;
  logic                sys_clk, rstn, cmd_valid, rsp_valid, pkt_valid, pkt_ready, rf_send;
  logic                rf_tx_done, rf_ack, pkt_done, pkt_acked, retry_active;
  parc_pkg::parc_cmd_t cmd;
  parc_pkg::parc_rsp_t rsp;
  logic         [15:0] pkt_ref, rf_ref;
  logic          [7:0] ack_on, lim_s, span_s;
  int                  mismatches, cmp_count, sends;
  // Rows: limit, span, acked send (0 none), expected sends, expected ack
  logic         [39:0] rows [0:6] = '{40'h00_00_01_01_00, 40'h03_00_01_01_01,
    40'h03_00_02_02_01, 40'h03_00_00_03_00, 40'h01_02_00_01_00, 40'h02_03_00_02_00,
    40'hFF_01_04_04_01};
  localparam int SLOT = 8; // Shortened slot so every wait fits the run
  parc_top #(.SLOT_CYCLES(SLOT)) parc_top_i (
    .sys_clk      (sys_clk),
    .rstn         (rstn),
    .cmd_valid    (cmd_valid),
    .cmd          (cmd),
    .rsp_valid    (rsp_valid),
    .rsp          (rsp),
    .pkt_valid    (pkt_valid),
    .pkt_ref      (pkt_ref),
    .pkt_ready    (pkt_ready),
    .rf_send      (rf_send),
    .rf_ref       (rf_ref),
    .rf_tx_done   (rf_tx_done),
    .rf_ack       (rf_ack),
    .pkt_done     (pkt_done),
    .pkt_acked    (pkt_acked),
    .retry_active (retry_active)
  );
  parc_radio parc_radio_i (.sys_clk(sys_clk), .rstn(rstn), .rf_send(rf_send), .clr(pkt_done),
    .ack_on(ack_on), .rf_tx_done(rf_tx_done), .rf_ack(rf_ack));
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  task report_and_stop;
    if (mismatches == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // One command, answer checked in the cycle it stands
  task cmd_io(input logic wr, input logic [7:0] code, input logic [7:0] wd, input logic [8:0] e);
    @(posedge sys_clk);
    #1;
    cmd_valid = 1'b1;
    cmd = {wr, code, wd};
    @(posedge sys_clk);
    #1;
    cmd_valid = 1'b0;
    cmp({15'h0000, rsp_valid}, 16'h0001, "answer strobe");
    cmp({7'h00, rsp}, {7'h00, e}, "answer");
  endtask
  // One packet from take to outcome, counting sends and the spacing of resends;
  // a resend follows tx_done by the ack window plus 0 to span-1 whole backoff slots
  task run_pkt(input logic [15:0] r, input logic [7:0] n, input logic a);
    int   gap;
    int   w;
    int   top;
    logic ok;
    sends = 0;
    gap = 0;
    w = (span_s == 8'h00) ? 1 : span_s;
    top = (span_s == 8'h00) ? 0 : span_s - 1;
    @(posedge sys_clk);
    #1;
    pkt_valid = 1'b1;
    pkt_ref = r;
    @(posedge sys_clk);
    #1;
    pkt_valid = 1'b0;
    pkt_ref = ~r; // A stale reference must never reach the radio
    for (int i = 0; i < 3000 && !pkt_done; i++) begin
      gap++;
      if (rf_tx_done === 1'b1) gap = 0;
      if (rf_send === 1'b1) begin
        if (sends > 0) begin
          ok = ((gap - 1) % SLOT == 0) && (gap >= 1 + SLOT * w) && (gap <= 1 + SLOT * (w + top));
          cmp({15'h0000, ok}, 16'h0001, "resend spacing");
        end
        sends++;
        cmp(rf_ref, r, "resent reference");
      end
      @(posedge sys_clk);
      #1;
    end
    cmp({15'h0000, pkt_done}, 16'h0001, "packet finished");
    cmp(sends[15:0], {8'h00, n}, "transmissions");
    cmp({15'h0000, pkt_acked}, {15'h0000, a}, "acknowledged");
    @(posedge sys_clk);
    #1;
    cmp({15'h0000, pkt_ready}, 16'h0001, "ready again");
  endtask
  initial begin
    {rstn, cmd_valid, pkt_valid} = '0;
    cmd = '0;
    pkt_ref = 16'h0000;
    {ack_on, lim_s, span_s} = '0;
    repeat (20) @(posedge sys_clk);
    #1;
    rstn = 1'b1;
    foreach (rows[k]) begin
      ack_on = rows[k][23:16];
      cmd_io(1'b1, 8'h18, rows[k][39:32], {1'b0, lim_s});
      cmd_io(1'b1, 8'h19, rows[k][31:24], {1'b0, span_s});
      lim_s = rows[k][39:32];
      span_s = rows[k][31:24];
      cmp({15'h0000, retry_active}, {15'h0000, lim_s != 8'h00}, "retries on");
      run_pkt({8'hC0, k[7:0]}, rows[k][15:8], rows[k][0]);
    end
    // Unknown code answers with an error and leaves the limit alone
    cmd_io(1'b1, 8'h20, 8'h55, 9'h100);
    cmd_io(1'b0, 8'h18, 8'h00, {1'b0, lim_s});
    // A reset in mid-run brings both parameters back to zero
    rstn = 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
    rstn = 1'b1;
    cmp({15'h0000, retry_active}, 16'h0000, "retries after reset");
    cmp({15'h0000, pkt_ready}, 16'h0001, "ready after reset");
    cmd_io(1'b0, 8'h18, 8'h00, 9'h000);
    cmd_io(1'b0, 8'h19, 8'h00, 9'h000);
    report_and_stop;
  end
  // Whole run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    report_and_stop;
  end
endmodule
bind parc_top parc_chk #(.SLOT_CYCLES(SLOT_CYCLES)) parc_chk_i (
  .sys_clk      (sys_clk),
  .rstn         (rstn),
  .cmd_valid    (cmd_valid),
  .cmd          (cmd),
  .rsp_valid    (rsp_valid),
  .rsp          (rsp),
  .pkt_valid    (pkt_valid),
  .pkt_ref      (pkt_ref),
  .pkt_ready    (pkt_ready),
  .rf_send      (rf_send),
  .rf_ref       (rf_ref),
  .rf_tx_done   (rf_tx_done),
  .rf_ack       (rf_ack),
  .pkt_done     (pkt_done),
  .pkt_acked    (pkt_acked),
  .retry_active (retry_active)
);
